// file: pbs_defs.svh
// constants of the pipelined burst sram port: widths, counts, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH

`define PBS_ADDR_W 17
`define PBS_DATA_W 32
`define PBS_LANES 4
`define PBS_BURST_W 2
`define PBS_SYNC_STAGES 3
`define PBS_SLEEP_CYCLES 2
`define PBS_STRAP_RESET 1'b1
`define PBS_LANES_OFF 4'hF

`endif

// file: pbs_pkg.sv
// types shared by the sram port, its controller model and the bench
// assumes pbs_defs.svh is on the include path
`default_nettype none
`include "pbs_defs.svh"

package pbs_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [`PBS_ADDR_W-1:0] addr;
    logic [`PBS_LANES-1:0] lane_n;
  } pbs_cmd_t;

  typedef struct packed {
    logic [`PBS_LANES-1:0] parity;
    logic [`PBS_DATA_W-1:0] data;
  } pbs_word_t;

  typedef enum logic [1:0] {
    PBS_AWAKE,
    PBS_ENTERING,
    PBS_ASLEEP,
    PBS_LEAVING
  } pbs_sleep_t;

endpackage

`default_nettype wire

// file: pbs_mem_core.sv
// storage array with one lane-masked write port and one combinational read
// assumes the caller registers read data and supplies write data aligned to lanes
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.svh"

module pbs_mem_core #(
  parameter int ADDR_W = `PBS_ADDR_W,
  parameter int DATA_W = `PBS_DATA_W,
  parameter int LANES = `PBS_LANES
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [LANES-1:0] wr_lane_n,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [LANES-1:0] wr_parity,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  output logic [LANES-1:0] rd_parity
);
  localparam int BYTE_W = DATA_W / LANES;

  logic [DATA_W-1:0] data_mem [0:(1<<ADDR_W)-1];
  logic [LANES-1:0] parity_mem [0:(1<<ADDR_W)-1];

  // unselected lanes keep their contents
  always_ff @(posedge clk) begin
    if (wr_en) begin
      for (int i = 0; i < LANES; i++) begin
        if (!wr_lane_n[i]) begin
          data_mem[wr_addr][i*BYTE_W +: BYTE_W] <= wr_data[i*BYTE_W +: BYTE_W];
          parity_mem[wr_addr][i] <= wr_parity[i];
        end
      end
    end
  end

  assign rd_data = data_mem[rd_addr];
  assign rd_parity = parity_mem[rd_addr];

endmodule // pbs_mem_core

`default_nettype wire

// file: pbs_sram_port.sv
// pipelined burst sram port: command pipeline, burst counter, bus drive, sleep
// assumes a controller on the same clock drives the synchronous inputs;
// sleep request, burst strap and output enable come from pins
//
// What this block does
// - clock gate high freezes all pipeline state while awake
// - gating never deselects, only stretches the cycle
// - sleep request enters sleep, contents kept
// - input data captured in register at edge
// - bus drives only with output enable low
// - tristate in write data, after deselect
// - parity lines follow their byte lane selects
// - strap low linear, high interleaved burst
// - load low and selected latches new address
// - write select low at load means write
// - only selected byte lanes are written
// - deselect is pipelined like a data phase
// - synchronous inputs and read data pass edge registers; output enable acts without one
// - writes complete internally without a strobe
// - read data drives after next clock rise
// - write data latched two rises after load
// - advance steps two-bit wrapping burst counter
// - sleep entry and exit take two cycles
//
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.svh"

module pbs_sram_port
  import pbs_pkg::*;
#(
  parameter int ADDR_W = `PBS_ADDR_W,
  parameter int SLEEP_CYCLES = `PBS_SLEEP_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clock_gate_n,
  input wire logic sleep_request,
  input wire logic burst_order_strap,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic advance_or_load,
  input wire logic write_n,
  input wire logic [`PBS_LANES-1:0] byte_lane_write_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic output_enable_n,
  input wire logic [`PBS_DATA_W-1:0] data_in,
  output logic [`PBS_DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [`PBS_LANES-1:0] parity_lines_in,
  output logic [`PBS_LANES-1:0] parity_lines_out,
  output logic parity_lines_oe,
  output logic asleep
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [`PBS_BURST_W-1:0] burst_step(
    input logic [`PBS_BURST_W-1:0] start,
    input logic [`PBS_BURST_W-1:0] count,
    input logic interleave
  );
    burst_step = interleave ? (start ^ count) : 2'(start + count);
  endfunction

  function automatic pbs_word_t lane_merge(
    input pbs_word_t base,
    input pbs_word_t upd,
    input logic [`PBS_LANES-1:0] lane_n
  );
    pbs_word_t res;
    res = base;
    for (int i = 0; i < `PBS_LANES; i++) begin
      if (!lane_n[i]) begin
        res.data[i*8 +: 8] = upd.data[i*8 +: 8];
        res.parity[i] = upd.parity[i];
      end
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers for sleep request and burst strap
  logic [`PBS_SYNC_STAGES-1:0] sleep_sync;
  logic [`PBS_SYNC_STAGES-1:0] strap_sync;
  logic sleep_level;
  logic interleave;

  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_sync <= '0;
      strap_sync <= {`PBS_SYNC_STAGES{`PBS_STRAP_RESET}};
    end else begin
      sleep_sync <= {sleep_sync[`PBS_SYNC_STAGES-2:0], sleep_request};
      strap_sync <= {strap_sync[`PBS_SYNC_STAGES-2:0], burst_order_strap};
    end
  end

  // a level counts once the second and third stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_level <= 1'b0;
      interleave <= `PBS_STRAP_RESET;
    end else begin
      if (sleep_sync[1] == sleep_sync[2]) begin
        sleep_level <= sleep_sync[2];
      end
      if (strap_sync[1] == strap_sync[2]) begin
        interleave <= strap_sync[2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sleep sequencing, runs on the raw clock
  pbs_sleep_t sleep_state;
  logic [1:0] sleep_cnt;
  logic awake;
  logic en;

  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_state <= PBS_AWAKE;
      sleep_cnt <= 2'h0;
    end else begin
      case (sleep_state)
        PBS_AWAKE: begin
          sleep_cnt <= 2'h0;
          if (sleep_level) begin
            sleep_state <= PBS_ENTERING;
          end
        end
        PBS_ENTERING: begin
          sleep_cnt <= 2'(sleep_cnt + 2'h1);
          if (sleep_cnt == 2'(SLEEP_CYCLES - 1)) begin
            sleep_state <= PBS_ASLEEP;
          end
        end
        PBS_ASLEEP: begin
          sleep_cnt <= 2'h0;
          if (!sleep_level) begin
            sleep_state <= PBS_LEAVING;
          end
        end
        PBS_LEAVING: begin
          sleep_cnt <= 2'(sleep_cnt + 2'h1);
          if (sleep_cnt == 2'(SLEEP_CYCLES - 1)) begin
            sleep_state <= PBS_AWAKE;
          end
        end
        default: begin
          sleep_state <= PBS_AWAKE;
          sleep_cnt <= 2'h0;
        end
      endcase
    end
  end

  assign awake = (sleep_state == PBS_AWAKE);
  assign asleep = (sleep_state == PBS_ASLEEP);
  // a masked edge leaves every pipeline register alone while awake
  assign en = !clock_gate_n && awake;

  //////////////////////////////////////////////////////////////////////////////
  // command stage: load, burst advance, deselect
  logic selected;
  pbs_cmd_t s1;
  logic [ADDR_W-1:0] burst_base;
  logic [`PBS_BURST_W-1:0] burst_cnt;
  logic burst_ok;

  assign selected = !chip_select_a_n && chip_select_b && !chip_select_c_n;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '{valid: 1'b0, write: 1'b0, addr: '0, lane_n: `PBS_LANES_OFF};
      burst_base <= '0;
      burst_cnt <= '0;
      burst_ok <= 1'b0;
    end else if (!awake) begin
      // pending accesses are dropped on the way into sleep
      s1.valid <= 1'b0;
      burst_ok <= 1'b0;
    end else if (en) begin
      if (!advance_or_load) begin
        if (selected) begin
          s1.valid <= 1'b1;
          s1.write <= !write_n;
          s1.addr <= address;
          s1.lane_n <= byte_lane_write_n;
          burst_base <= address;
          burst_cnt <= '0;
          burst_ok <= 1'b1;
        end else begin
          s1.valid <= 1'b0;
          burst_ok <= 1'b0;
        end
      end else if (burst_ok) begin
        // type held, selects and write select not looked at
        burst_cnt <= 2'(burst_cnt + 2'h1);
        s1.valid <= 1'b1;
        s1.addr <= {burst_base[ADDR_W-1:`PBS_BURST_W],
                    burst_step(burst_base[`PBS_BURST_W-1:0], 2'(burst_cnt + 2'h1), interleave)};
        s1.lane_n <= byte_lane_write_n;
      end else begin
        s1.valid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data phase and write commit stages
  pbs_cmd_t s2;
  pbs_cmd_t s3;
  pbs_word_t din_reg;
  pbs_word_t pin_word;

  assign pin_word = '{parity: parity_lines_in, data: data_in};

  always_ff @(posedge clk) begin
    if (srst) begin
      s2 <= '{valid: 1'b0, write: 1'b0, addr: '0, lane_n: `PBS_LANES_OFF};
      s3 <= '{valid: 1'b0, write: 1'b0, addr: '0, lane_n: `PBS_LANES_OFF};
    end else if (!awake) begin
      s2.valid <= 1'b0;
      s3.valid <= 1'b0;
    end else if (en) begin
      s2 <= s1;
      s3 <= s2;
      s3.valid <= s2.valid && s2.write;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      din_reg <= '0;
    end else if (en) begin
      din_reg <= pin_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // storage and read forwarding
  pbs_word_t mem_word;
  pbs_word_t fwd_word;
  logic commit;

  // self-timed commit of the word latched one edge earlier
  assign commit = en && s3.valid;

  pbs_mem_core #(
    .ADDR_W(ADDR_W),
    .DATA_W(`PBS_DATA_W),
    .LANES(`PBS_LANES)
  ) u_core (
    .clk(clk),
    .wr_en(commit),
    .wr_addr(s3.addr),
    .wr_lane_n(s3.lane_n),
    .wr_data(din_reg.data),
    .wr_parity(din_reg.parity),
    .rd_addr(s1.addr),
    .rd_data(mem_word.data),
    .rd_parity(mem_word.parity)
  );

  // newer writes still in flight override the array
  always_comb begin
    fwd_word = mem_word;
    if (s3.valid && (s3.addr == s1.addr)) begin
      fwd_word = lane_merge(fwd_word, din_reg, s3.lane_n);
    end
    if (s2.valid && s2.write && (s2.addr == s1.addr)) begin
      fwd_word = lane_merge(fwd_word, pin_word, s2.lane_n);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output register and bus direction
  pbs_word_t out_word;
  logic out_drive;

  always_ff @(posedge clk) begin
    if (srst) begin
      out_word <= '0;
      out_drive <= 1'b0;
    end else if (!awake) begin
      out_drive <= 1'b0;
    end else if (en) begin
      // write data cycles, deselects and the cycle after reselect stay off
      out_drive <= s1.valid && !s1.write;
      if (s1.valid && !s1.write) begin
        out_word <= fwd_word;
      end
    end
  end

  assign data_out = out_word.data;
  assign parity_lines_out = out_word.parity;
  assign data_oe = out_drive && !output_enable_n && awake;
  assign parity_lines_oe = data_oe;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence seq_read_load;
    en && !advance_or_load && selected && write_n;
  endsequence
  sequence seq_write_load;
    en && !advance_or_load && selected && !write_n;
  endsequence
  sequence seq_deselect;
    en && !advance_or_load && !selected;
  endsequence

  a_gate_freeze: assert property (
    (clock_gate_n && awake && !sleep_level) |=> ($stable(s1) && $stable(s2) && $stable(out_word)))
    else $error("pipeline moved on a gated edge");
  a_gate_keeps_select: assert property (
    (clock_gate_n && s1.valid && awake && !sleep_level) |=> s1.valid)
    else $error("gated edge deselected the device");
  a_sleep_quiet: assert property (
    (sleep_state == PBS_ASLEEP) |-> (!data_oe && !s1.valid && !s2.valid))
    else $error("activity while asleep");
  a_oe_masks_bus: assert property (
    output_enable_n |-> (!data_oe && !parity_lines_oe))
    else $error("bus driven with output enable high");
  a_write_phase_off: assert property (
    (s2.valid && s2.write) |-> !data_oe)
    else $error("bus driven in write data cycle");
  a_read_latency: assert property (
    (seq_read_load ##1 (en && !output_enable_n && !sleep_level)) |=> data_oe)
    else $error("read data not driven after next rise");
  a_write_turnaround: assert property (
    (seq_write_load ##1 en) |=> (!data_oe && s2.valid && s2.write))
    else $error("write data phase not tristated");
  a_deselect_pipe: assert property (
    (seq_deselect ##1 en) |=> !out_drive)
    else $error("deselect did not reach the bus");
  a_load_address: assert property (
    (seq_write_load or seq_read_load) |=> (s1.valid && s1.addr == $past(address)))
    else $error("address not loaded");
  a_load_type: assert property (
    (en && !advance_or_load && selected) |=> (s1.write == !$past(write_n)))
    else $error("access type wrong at load");
  a_burst_type_kept: assert property (
    (en && advance_or_load && burst_ok) |=> (s1.valid && $stable(s1.write)))
    else $error("burst changed access type");
  a_burst_linear: assert property (
    (en && advance_or_load && burst_ok && !interleave)
      |=> (s1.addr[1:0] == 2'($past(s1.addr[1:0]) + 2'h1)))
    else $error("linear burst step wrong");
  a_sleep_entry: assert property (
    (sleep_state == PBS_AWAKE && sleep_level) |=> (sleep_state == PBS_ENTERING)[*2]
      ##1 (sleep_state == PBS_ASLEEP))
    else $error("sleep entry not two cycles");

endmodule // pbs_sram_port

`default_nettype wire

// file: pbs_ctrl_model.sv
// controller model for the sram port: command pins, write data phase, sleep pin
// assumes the bench calls op, gate and sleep, and merges the bus from both drivers
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.svh"

module pbs_ctrl_model
  import pbs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  output logic clock_gate_n,
  output logic sleep_request,
  output logic chip_select_a_n,
  output logic chip_select_b,
  output logic chip_select_c_n,
  output logic advance_or_load,
  output logic write_n,
  output logic [`PBS_LANES-1:0] byte_lane_write_n,
  output logic [`PBS_ADDR_W-1:0] address,
  output pbs_word_t drv_word,
  output logic drv_oe,
  output pbs_cmd_t due
);
  pbs_cmd_t s0, s1;
  pbs_word_t d0, d1, d2;

  initial begin
    clock_gate_n = 1'b0;
    sleep_request = 1'b0;
    {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'b101;
    advance_or_load = 1'b0;
    write_n = 1'b1;
    byte_lane_write_n = 4'hF;
    address = '0;
    s0 = '0;
    d0 = '0;
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '0;
      due <= '0;
    end else if (!clock_gate_n) begin
      s1 <= s0;
      due <= s1;
    end
  end

  always_ff @(posedge clk) begin
    if (!clock_gate_n) begin
      d1 <= d0;
      d2 <= d1;
    end
  end

  // data only in the write data cycle, otherwise an inverted stale pattern
  assign drv_oe = due.valid & due.write;
  assign drv_word = drv_oe ? d2 : ~d2;

  // ld 1 loads, 0 advances; sel 0 with ld 1 deselects
  task automatic op(input logic ld, input logic sel, input logic wr,
      input logic [`PBS_ADDR_W-1:0] a, input logic [3:0] ln, input pbs_word_t d);
    @(posedge clk);
    clock_gate_n <= 1'b0;
    advance_or_load <= !ld;
    chip_select_a_n <= !(sel && ld);
    chip_select_b <= sel && ld;
    chip_select_c_n <= !(sel && ld);
    write_n <= ld ? !wr : wr;
    byte_lane_write_n <= ln;
    address <= ld ? a : ~a;
    s0 <= '{valid: sel, write: wr, addr: a, lane_n: ln};
    d0 <= d;
  endtask

  task automatic gate(input int n);
    repeat (n) begin
      @(posedge clk);
      clock_gate_n <= 1'b1;
    end
  endtask

  task automatic sleep(input logic v);
    @(posedge clk);
    sleep_request <= v;
  endtask
endmodule // pbs_ctrl_model
`default_nettype wire

// file: pbs_sram_port_test.sv
// self-checking bench for the sram port with a controller model on its bus
// assumes the design package and defines header are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.svh"

`define CHK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
  end

module pbs_sram_port_test
  import pbs_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic strap = 1'b1;
  logic oe_n = 1'b0;
  logic clock_gate_n, sleep_request, chip_select_a_n, chip_select_b, chip_select_c_n;
  logic advance_or_load, write_n, data_oe, parity_lines_oe, asleep, drv_oe;
  logic [3:0] byte_lane_write_n, parity_lines_out;
  logic [`PBS_ADDR_W-1:0] address;
  logic [`PBS_DATA_W-1:0] data_out;
  pbs_word_t drv_word, bus;
  pbs_cmd_t due;
  pbs_word_t ref_mem [int];
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;

  always #2.5 clk = ~clk;
  assign bus = data_oe ? {parity_lines_out, data_out} : drv_word;

  pbs_sram_port u_dut (
    .clk(clk), .srst(srst), .clock_gate_n(clock_gate_n), .sleep_request(sleep_request),
    .burst_order_strap(strap), .chip_select_a_n(chip_select_a_n),
    .chip_select_b(chip_select_b), .chip_select_c_n(chip_select_c_n),
    .advance_or_load(advance_or_load), .write_n(write_n),
    .byte_lane_write_n(byte_lane_write_n), .address(address), .output_enable_n(oe_n),
    .data_in(bus.data), .data_out(data_out), .data_oe(data_oe),
    .parity_lines_in(bus.parity), .parity_lines_out(parity_lines_out),
    .parity_lines_oe(parity_lines_oe), .asleep(asleep)
  );

  pbs_ctrl_model u_c (
    .clk(clk), .srst(srst), .clock_gate_n(clock_gate_n), .sleep_request(sleep_request),
    .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
    .chip_select_c_n(chip_select_c_n), .advance_or_load(advance_or_load),
    .write_n(write_n), .byte_lane_write_n(byte_lane_write_n), .address(address),
    .drv_word(drv_word), .drv_oe(drv_oe), .due(due)
  );

  function automatic pbs_word_t merge(pbs_word_t old, pbs_word_t nw, logic [3:0] ln);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (!ln[i]) begin
        merge.data[8*i +: 8] = nw.data[8*i +: 8];
        merge.parity[i] = nw.parity[i];
      end
  endfunction

  function automatic logic [16:0] baddr(logic [16:0] a, int k);
    baddr = a;
    baddr[1:0] = strap ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
  endfunction

  function automatic pbs_word_t word(int i);
    word = {4'(i ^ 5), 32'h9E3779B9 * 32'(i + 1)};
  endfunction

  ////////////////////////////////////////////////////////////////
  // bus direction checked on every cycle, read data on every read with output enable low
  always @(negedge clk) begin
    if (!srst) begin
      `CHK("bus drive", due.valid & !due.write & !oe_n, data_oe)
      `CHK("parity drive", data_oe, parity_lines_oe)
      if (due.valid && !due.write && !oe_n)
        `CHK("read word", ref_mem[due.addr], bus)
      if (drv_oe)
        ref_mem[due.addr] = merge(ref_mem[due.addr], drv_word, due.lane_n);
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic idle(input int k);
    repeat (k) u_c.op(1'b1, 1'b0, 1'b0, '0, 4'hF, '0);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    logic [16:0] base;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    `CHK("reset drive", 1'b0, data_oe)
    `CHK("reset sleep", 1'b0, asleep)
    `CHK("reset data", 32'h0, data_out)
    idle(4);
    done("reset");
    for (int l = 0; l < 16; l++) begin
      u_c.op(1'b1, 1'b1, 1'b1, 17'h00020, l[3:0], word(l));
      u_c.op(1'b1, 1'b1, 1'b0, 17'h00020, 4'hF, '0);
    end
    idle(3);
    done("byte lanes");
    for (int s = 1; s >= 0; s--) begin
      strap <= s[0];
      idle(5);
      base = s ? 17'h00101 : 17'h00102;
      for (int k = 0; k < 4; k++)
        u_c.op(k == 0, 1'b1, 1'b1, baddr(base, k), 4'h0, word(10 + k + 4 * s));
      for (int k = 0; k < 4; k++)
        u_c.op(1'b1, 1'b1, 1'b0, baddr(base, k), 4'hF, '0);
      for (int k = 0; k < 4; k++) begin
        u_c.op(k == 0, 1'b1, 1'b0, baddr(base, k), 4'hF, '0);
        if (k == 1)
          u_c.gate(3);
      end
      idle(3);
    end
    done("bursts");
    u_c.op(1'b1, 1'b1, 1'b0, 17'h00020, 4'hF, '0);
    oe_n <= 1'b1;
    u_c.op(1'b1, 1'b1, 1'b0, 17'h00101, 4'hF, '0);
    idle(2);
    oe_n <= 1'b0;
    u_c.op(1'b0, 1'b0, 1'b0, 17'h00020, 4'hF, '0);
    idle(2);
    done("output enable");
    u_c.sleep(1'b1);
    n = 0;
    while (asleep !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    `CHK("asleep", 1'b1, asleep)
    `CHK("entry time", 1'b1, n > 2)
    u_c.sleep(1'b0);
    n = 0;
    while (asleep !== 1'b0 && n < 12) begin
      @(negedge clk);
      n++;
    end
    `CHK("awake", 1'b0, asleep)
    idle(4);
    u_c.op(1'b1, 1'b1, 1'b0, 17'h00020, 4'hF, '0);
    u_c.op(1'b1, 1'b1, 1'b0, 17'h00102, 4'hF, '0);
    idle(3);
    done("sleep");
    tally_and_finish();
  end
endmodule // pbs_sram_port_test
`default_nettype wire
